// file: hw/idle_standby_timer.sv
module idle_standby_timer
    import idle_timer_pkg::*;
#(
    parameter int TICKS_PER_SEC = CLK_HZ
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] sect_count,
    input  wire logic       host_access,
    input  wire logic       spindle_at_speed,
    output logic            cmd_done,
    output logic [7:0]      status,
    output logic [7:0]      error,
    output logic            spin_up_req,
    output logic            spin_down_req,
    output logic [1:0]      power_mode,
    output logic            timer_enabled
);
    import idle_timer_pkg::*;

    // Decode a timeout code into seconds
    function automatic logic [SEC_W-1:0] code_secs(input logic [7:0] c);
        logic [SEC_W-1:0] s;
        s = '0;
        if (c == CODE_OFF) begin
            s = '0;
        end else if (c <= CODE_STEP_MAX) begin
            s = SEC_W'(c) * SEC_W'(STEP_S);
        end else if (c <= CODE_HALF_MAX) begin
            s = SEC_W'(c - CODE_STEP_MAX) * SEC_W'(HALF_HOUR_S);
        end else if (c == CODE_21M) begin
            s = SEC_W'(T21M_S);
        end else if (c == CODE_8H) begin
            s = SEC_W'(T8H_S);
        end else begin
            s = SEC_W'(T21M15S_S);
        end
        return s;
    endfunction

    // Idle command recogniser, accepts both opcodes
    function automatic logic is_idle(input logic [7:0] c);
        return (c == CMD_IDLE) || (c == CMD_IDLE_LEGACY);
    endfunction

    // Whole control state in one word, registered as a unit
    typedef struct packed {
        pm_t              mode;
        logic             en;
        logic [SEC_W-1:0] secs;
        logic             done;
        logic [7:0]       stat;
        logic [7:0]       err;
        logic             spin_req;
        logic             down_req;
        logic             ld;
        logic             stp;
    } top_st_t;

    top_st_t st_q;  // Registered state
    top_st_t st_d;  // Next state

    // Link to the seconds counter
    tmr_if tif ();

    // Counter sees load/stop from registered state
    assign tif.load = st_q.ld;
    assign tif.stop = st_q.stp;
    assign tif.secs = st_q.secs;

    // Prescaled seconds counter; a low clock enable stalls it too
    standby_counter #(
        .TICKS_PER_SEC(TICKS_PER_SEC)
    ) u_cnt (
        .core_clk(core_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .t       (tif.cnt)
    );

    // Outputs straight from flops
    assign cmd_done      = st_q.done;
    assign status        = st_q.stat;
    assign error         = st_q.err;
    assign spin_up_req   = st_q.spin_req;
    assign spin_down_req = st_q.down_req;
    assign power_mode    = st_q.mode;
    assign timer_enabled = st_q.en;

    // Command, mode and timer control
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        st_d.ld   = 1'b0;
        st_d.stp  = 1'b0;
        // Seek-complete follows the spindle one cycle late
        st_d.stat[ST_DSC] = spindle_at_speed;
        if (cmd_valid && is_idle(cmd_code)) begin
            st_d.done = 1'b1;
            st_d.stat[ST_BSY] = 1'b0;
            st_d.stat[ST_DF]  = 1'b0;
            if (sect_count == CODE_ABORT) begin
                // Rejected: mode and timer untouched
                st_d.stat[ST_ERR] = 1'b1;
                st_d.err[ER_ABT]  = 1'b1;
            end else begin
                // Accepted: earlier abort flags are cleared
                st_d.stat[ST_ERR] = 1'b0;
                st_d.err[ER_ABT]  = 1'b0;
                st_d.stat[ST_RDY] = 1'b1;
                st_d.down_req     = 1'b0;
                // Skip spin-up when already at speed
                st_d.mode = spindle_at_speed ? PM_IDLE : PM_SPINUP;
                st_d.spin_req = !spindle_at_speed;
                st_d.secs = code_secs(sect_count);
                // Zero parks the counter; anything else arms it
                if (sect_count == CODE_OFF) begin
                    st_d.en  = 1'b0;
                    st_d.stp = 1'b1;
                end else begin
                    st_d.en = 1'b1;
                    st_d.ld = 1'b1;
                end
            end
        end else begin
            // Not an Idle command: error bits, timer and spin-up completion
            if (cmd_valid) begin
                // Other commands clear prior error bits
                st_d.stat[ST_ERR] = 1'b0;
                st_d.err[ER_ABT]  = 1'b0;
            end
            // Any host access restarts interval; wins over expiry
            if ((host_access || cmd_valid) && st_q.en) begin
                st_d.ld = 1'b1;
            end else if (tif.expired && st_q.en) begin
                st_d.mode     = PM_STANDBY;
                st_d.down_req = 1'b1;
                st_d.spin_req = 1'b0;
            end
            // Looks at the next mode so that an expiry in this cycle
            // is not undone by a spin-up that finishes at the same time
            if (st_d.mode == PM_SPINUP && spindle_at_speed) begin
                st_d.mode     = PM_IDLE;
                st_d.spin_req = 1'b0;
            end
        end
    end

    // State register, frozen by clock enable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Assertions
    // Each trigger except p_done_clean includes clk_en: a frozen edge takes no command,
    // so nothing is promised for the edge after it
    property p_abort_flags;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count == CODE_ABORT)
        |=> (status[ST_ERR] && error[ER_ABT] && cmd_done);
    endproperty
    a_abort_flags: assert property (p_abort_flags)
        else $error("abort code not flagged");

    property p_zero_off;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count == CODE_OFF)
        |=> !timer_enabled;
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("zero code left timer on");

    property p_enable;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count != CODE_OFF
         && sect_count != CODE_ABORT) |=> (timer_enabled && st_q.ld);
    endproperty
    a_enable: assert property (p_enable)
        else $error("nonzero code did not arm timer");

    property p_spin;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count != CODE_ABORT)
        |=> (spin_up_req == !$past(spindle_at_speed) && power_mode != PM_STANDBY);
    endproperty
    a_spin: assert property (p_spin)
        else $error("spin-up request wrong");

    property p_done_clean;
        @(posedge core_clk) disable iff (!resetn)
        cmd_done |-> (!status[ST_BSY] && !status[ST_DF]);
    endproperty
    a_done_clean: assert property (p_done_clean)
        else $error("busy or fault on completion");

    property p_expire;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && tif.expired && timer_enabled && !host_access && !cmd_valid)
        |=> (power_mode == PM_STANDBY && spin_down_req);
    endproperty
    a_expire: assert property (p_expire)
        else $error("no standby on expiry");

    // Two-step reload: load pulse, then the counter is armed
    sequence s_reloaded;
        st_q.ld ##1 (tif.running || st_q.ld);
    endsequence

    property p_reload;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && host_access && timer_enabled && !cmd_valid)
        |=> s_reloaded;
    endproperty
    a_reload: assert property (p_reload)
        else $error("access did not reload timer");

    property p_legacy;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && cmd_code == CMD_IDLE_LEGACY) |=> cmd_done;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy code not taken");

    // Two-step stop: stop pulse, then the counter is disarmed
    sequence s_stopped;
        st_q.stp ##1 (!tif.running || st_q.stp);
    endsequence

    property p_zero_stop;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count == CODE_OFF)
        |=> s_stopped;
    endproperty
    a_zero_stop: assert property (p_zero_stop)
        else $error("zero code left counter armed");

    // Rejected command must leave mode and timer as they were
    property p_abort_keeps;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count == CODE_ABORT)
        |=> (power_mode == $past(power_mode)
             && timer_enabled == $past(timer_enabled));
    endproperty
    a_abort_keeps: assert property (p_abort_keeps)
        else $error("abort code changed mode or timer");

    // Codes in the five-second band load code times five seconds
    property p_step_decode;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count != CODE_OFF
         && sect_count <= CODE_STEP_MAX)
        |=> (int'(tif.secs) == int'($past(sect_count)) * STEP_S);
    endproperty
    a_step_decode: assert property (p_step_decode)
        else $error("five second band decoded wrong");

    // Codes above that band up to CODE_HALF_MAX load whole half hours
    property p_half_decode;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code)
         && sect_count > CODE_STEP_MAX && sect_count <= CODE_HALF_MAX)
        |=> (int'(tif.secs) == HALF_HOUR_S
             * (int'($past(sect_count)) - int'(CODE_STEP_MAX)));
    endproperty
    a_half_decode: assert property (p_half_decode)
        else $error("half hour band decoded wrong");

    // Accepted Idle leaves the drive ready and out of standby
    property p_ready;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && cmd_valid && is_idle(cmd_code) && sect_count != CODE_ABORT)
        |=> (status[ST_RDY] && !spin_down_req);
    endproperty
    a_ready: assert property (p_ready)
        else $error("idle not ready at once");

    // Spin-up ends once the spindle reports speed
    property p_spin_done;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && power_mode == PM_SPINUP && spindle_at_speed && !cmd_valid
         && !tif.expired) |=> (power_mode == PM_IDLE && !spin_up_req);
    endproperty
    a_spin_done: assert property (p_spin_done)
        else $error("spin-up never finished");

    // Completion only ever follows an Idle command
    property p_done_source;
        @(posedge core_clk) disable iff (!resetn)
        (cmd_done && $past(clk_en))
        |-> ($past(cmd_valid) && is_idle($past(cmd_code)));
    endproperty
    a_done_source: assert property (p_done_source)
        else $error("completion without an idle command");
endmodule

// file: hw/idle_timer_pkg.sv
package idle_timer_pkg;
    // Command codes
    localparam logic [7:0] CMD_IDLE        = 8'hE3;
    localparam logic [7:0] CMD_IDLE_LEGACY = 8'h97;
    // Timeout code boundaries
    localparam logic [7:0] CODE_OFF        = 8'h00;
    localparam logic [7:0] CODE_STEP_MAX   = 8'hF0;
    localparam logic [7:0] CODE_HALF_MAX   = 8'hFB;
    localparam logic [7:0] CODE_21M        = 8'hFC;
    localparam logic [7:0] CODE_8H         = 8'hFD;
    localparam logic [7:0] CODE_ABORT      = 8'hFE;
    localparam logic [7:0] CODE_21M15S     = 8'hFF;
    // Interval units, in seconds
    localparam int STEP_S       = 5;
    localparam int HALF_HOUR_S  = 1800;
    localparam int T21M_S       = 1260;
    localparam int T8H_S        = 28800;
    localparam int T21M15S_S    = 1275;
    // Clock rate
    localparam int CLK_HZ       = 250_000_000;
    localparam int SEC_W        = 16;
    localparam int TICK_W       = 32;
    // Status and error bit positions
    localparam int ST_ERR = 0;
    localparam int ST_DSC = 4;
    localparam int ST_DF  = 5;
    localparam int ST_RDY = 6;
    localparam int ST_BSY = 7;
    localparam int ER_ABT = 2;
    // Power modes
    typedef enum logic [1:0] {PM_STANDBY, PM_SPINUP, PM_IDLE} pm_t;
endpackage

// file: hw/standby_counter.sv
// Seconds down-counter driven by a one-second prescaler
module standby_counter
    import idle_timer_pkg::*;
#(
    parameter int TICKS_PER_SEC = CLK_HZ
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic clk_en,
    tmr_if.cnt        t
);
    typedef struct packed {
        logic              run;
        logic [SEC_W-1:0]  secs;
        logic [TICK_W-1:0] pre;
        logic              exp;
    } cnt_st_t;

    cnt_st_t st_q;  // Registered state
    cnt_st_t st_d;  // Next state

    localparam logic [TICK_W-1:0] PRE_TOP = TICK_W'(TICKS_PER_SEC - 1);

    assign t.expired = st_q.exp;
    assign t.running = st_q.run;

    // Count down one second per prescaler wrap
    always_comb begin
        st_d     = st_q;
        st_d.exp = 1'b0;
        if (t.stop) begin
            st_d.run = 1'b0;
        end else if (t.load) begin
            // Host access restarts the full interval
            st_d.run  = 1'b1;
            st_d.secs = t.secs;
            st_d.pre  = PRE_TOP;
        end else if (st_q.run) begin
            if (st_q.pre != '0) begin
                st_d.pre = st_q.pre - 1'b1;
            end else if (st_q.secs <= SEC_W'(1)) begin
                st_d.run = 1'b0;
                st_d.exp = 1'b1;
            end else begin
                st_d.secs = st_q.secs - 1'b1;
                st_d.pre  = PRE_TOP;
            end
        end
    end

    // State register, frozen by clock enable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end
endmodule

// file: hw/tmr_if.sv
// Carries the loaded interval and the expiry pulse between top and counter
interface tmr_if import idle_timer_pkg::*; ();
    logic             load;     // Reload pulse
    logic             stop;     // Disable pulse
    logic [SEC_W-1:0] secs;     // Interval in seconds
    logic             expired;  // One-cycle expiry pulse
    logic             running;  // Counter armed
    modport ctl (output load, output stop, output secs,
                 input expired, input running);
    modport cnt (input load, input stop, input secs,
                 output expired, output running);
endinterface

// file: sim/host_model.sv
// Host controller side: issues commands and drive accesses
module host_model
    import idle_timer_pkg::*;
(
    input  wire logic       core_clk,
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic [7:0]      sect_count,
    output logic            host_access
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quiet lines from time zero
    initial begin
        cmd_valid   = 1'b0;
        cmd_code    = 8'h00;
        sect_count  = 8'h00;
        host_access = 1'b0;
    end
    // One command held for exactly one taking edge
    task automatic issue(input logic [7:0] code, input logic [7:0] tmo);
        @(posedge core_clk);
        cmd_valid  <= 1'b1;
        cmd_code   <= code;
        sect_count <= tmo;
        @(posedge core_clk);
        cmd_valid  <= 1'b0;
        // Stale fields inverted so nothing can latch them by luck
        cmd_code   <= ~code;
        sect_count <= ~tmo;
    endtask
    // Single-cycle drive access
    task automatic touch();
        @(posedge core_clk);
        host_access <= 1'b1;
        @(posedge core_clk);
        host_access <= 1'b0;
    endtask
endmodule

// file: sim/test_idle_standby_timer.sv
// Self-checking bench for the idle command and standby timer
module test_idle_standby_timer;
    timeunit 1ns;
    timeprecision 100ps;
    import idle_timer_pkg::*;
    localparam int TPS = 4; // Short second keeps the run brief
    logic       core_clk, resetn, clk_en, spindle_at_speed;
    logic       cmd_valid, host_access, cmd_done;
    logic       spin_up_req, spin_down_req, timer_enabled;
    logic [7:0] cmd_code, sect_count, status, error;
    logic [1:0] power_mode;
    int         failures, total_checks;
    int         secs_tab [5] = '{5, 1200, 1800, 1260, 1275};
    logic [7:0] code_tab [5] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFF};

    idle_standby_timer #(.TICKS_PER_SEC(TPS)) idle_standby_timer_inst (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .sect_count(sect_count), .host_access(host_access),
        .spindle_at_speed(spindle_at_speed), .cmd_done(cmd_done),
        .status(status), .error(error), .spin_up_req(spin_up_req),
        .spin_down_req(spin_down_req), .power_mode(power_mode),
        .timer_enabled(timer_enabled));
    host_model host_model_inst (
        .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .sect_count(sect_count), .host_access(host_access));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Idle command; done stands right after the taking edge, then gone
    task automatic run_idle(input logic [7:0] code, input logic [7:0] tmo,
                            input logic en, input logic [1:0] mode);
        host_model_inst.issue(code, tmo);
        #1;
        chk("done", 8'h01, 8'(cmd_done));
        chk("enable", 8'(en), 8'(timer_enabled));
        chk("mode", 8'(mode), 8'(power_mode));
        chk("busy fault err", 8'h00, status & 8'hA1);
        chk("ready", 8'h40, status & 8'h40);
        @(posedge core_clk);
        #1;
        chk("done drop", 8'h00, 8'(cmd_done));
    endtask
    // Cycles until standby, judged against a window
    task automatic wait_standby(input int exp);
        int n;
        n = 0;
        while (power_mode !== PM_STANDBY) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > exp + 8) begin
                failures++;
                $display("wrong value expiry expected %0d seen none", exp);
                conclude();
            end
        end
        chk("early expiry", 8'h00, 8'(n < exp - 2));
        chk("late expiry", 8'h00, 8'(n > exp + 3));
        chk("spin down", 8'h01, 8'(spin_down_req));
    endtask
    // Both codes, disable by zero, long code accepted
    task automatic s_codes();
        run_idle(CMD_IDLE_LEGACY, 8'h01, 1'b1, PM_IDLE);
        run_idle(CMD_IDLE, CODE_OFF, 1'b0, PM_IDLE);
        repeat (40) @(posedge core_clk);
        #1;
        chk("no expiry", 8'(PM_IDLE), 8'(power_mode));
        chk("no spin up", 8'h00, 8'(spin_up_req));
        run_idle(CMD_IDLE, CODE_8H, 1'b1, PM_IDLE);
    endtask
    // Reserved code rejected, other command clears error
    task automatic s_abort();
        host_model_inst.issue(CMD_IDLE, CODE_ABORT);
        #1;
        chk("abort done", 8'h01, 8'(cmd_done));
        chk("abt", 8'h04, error);
        chk("err", 8'h01, status & 8'hA1);
        chk("kept enable", 8'h01, 8'(timer_enabled));
        host_model_inst.issue(8'hEC, 8'h00);
        #1;
        chk("other done", 8'h00, 8'(cmd_done));
        chk("abt clear", 8'h00, error);
    endtask
    // Stopped spindle is spun up first
    task automatic s_spinup();
        @(posedge core_clk);
        spindle_at_speed <= 1'b0;
        run_idle(CMD_IDLE, CODE_OFF, 1'b0, PM_SPINUP);
        chk("spin req", 8'h01, 8'(spin_up_req));
        @(posedge core_clk);
        spindle_at_speed <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("at speed", 8'(PM_IDLE), 8'(power_mode));
    endtask
    // Every interval band except the eight-hour code runs to standby
    task automatic s_expiry();
        for (int i = 0; i < 5; i++) begin
            run_idle(CMD_IDLE, code_tab[i], 1'b1, PM_IDLE);
            wait_standby(secs_tab[i] * TPS);
        end
    endtask
    // Access late in the interval restarts the full count
    task automatic s_reload();
        run_idle(CMD_IDLE, 8'h01, 1'b1, PM_IDLE);
        repeat (10) @(posedge core_clk);
        host_model_inst.touch();
        wait_standby(5 * TPS);
    endtask

    // Low clock enable stalls the countdown, then it resumes
    task automatic s_freeze();
        run_idle(CMD_IDLE, 8'h01, 1'b1, PM_IDLE);
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (40) @(posedge core_clk);
        #1;
        chk("frozen mode", 8'(PM_IDLE), 8'(power_mode));
        chk("frozen enable", 8'h01, 8'(timer_enabled));
        @(posedge core_clk);
        clk_en <= 1'b1;
        wait_standby(5 * TPS);
    endtask

    // Reset, then the scenarios
    initial begin
        failures = 0;
        total_checks = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        spindle_at_speed = 1'b1;
        repeat (16) @(posedge core_clk);
        #1;
        chk("reset mode", 8'(PM_STANDBY), 8'(power_mode));
        chk("reset status", 8'h00, status);
        @(posedge core_clk);
        resetn <= 1'b1;
        s_codes();
        s_abort();
        s_spinup();
        s_expiry();
        s_reload();
        s_freeze();
        conclude();
    end
endmodule
